// ==== logic/clock_gen_dev.sv ====
module clock_gen_dev
    import clock_gen_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    clock_gen_if.dev link,
    output logic cpu_clk_out,
    output logic periph_clk_out,
    output logic ready_out,
    output logic reset_out,
    output logic osc_out,
    output logic ext_src_out,
    output logic clk_rise_out,
    output logic clk_fall_out
);

    dev_state_t state;
    dev_state_t next_state;
    logic src_level;
    logic src_rise;
    logic rdy_valid;
    logic [1:0] rdy_in;
    logic [1:0] qual_in_n;
    logic [1:0] rdy_qual;
    logic [1:0] cnt_step;
    logic next_clk;
    logic rise_evt;
    logic fall_evt;

    // ready input counts only while its qualifier is low
    function automatic logic qual_ready(
        input logic rdy,
        input logic qual_n
    );
        qual_ready = rdy & ~qual_n;
    endfunction : qual_ready

    // level change in one direction between two samples
    function automatic logic clk_edge(
        input logic now_level,
        input logic was_level,
        input logic rising
    );
        if (rising)
        begin
            clk_edge = now_level & ~was_level;
        end
        else
        begin
            clk_edge = ~now_level & was_level;
        end
    endfunction : clk_edge

    // next divide count: clear wins, then wrap after the last
    function automatic logic [1:0] div_step(
        input logic [1:0] cnt,
        input logic clear
    );
        if (clear)
        begin
            div_step = DIV_RESET;
        end
        else if (cnt == DIV_LAST)
        begin
            div_step = DIV_RESET;
        end
        else
        begin
            div_step = cnt + 2'h1;
        end
    endfunction : div_step

    // selected source: crystal level or external frequency
    assign src_level = state.src_ext ?
        link.ext_freq_in : link.xtal_in_a;
    assign src_rise = clk_edge(src_level, state.src_prev, 1'b1);

    // either qualified input makes the bus ready
    assign rdy_in = {link.bus_rdy_b, link.bus_rdy_a};
    assign qual_in_n = {link.bus_qual_b_n, link.bus_qual_a_n};

    for (genvar i = 0; i < 2; i++)
    begin : g_qual
        assign rdy_qual[i] = qual_ready(rdy_in[i], qual_in_n[i]);
    end

    assign rdy_valid = |rdy_qual;

    always_comb
    begin
        next_state = state;
        cnt_step = DIV_RESET;
        next_clk = 1'b0;
        rise_evt = 1'b0;
        fall_evt = 1'b0;

        // strap is caught once, on the first edge after reset
        if (!state.strap_taken)
        begin
            next_state.strap_taken = 1'b1;
            next_state.src_ext = link.ext_src_sel;
        end

        next_state.src_prev = src_level;
        next_state.osc = link.xtal_in_a;

        // divide by three on each rising source edge
        if (src_rise)
        begin
            cnt_step = div_step(state.div_cnt, link.divider_clear);
            next_state.div_cnt = cnt_step;
            next_clk = (cnt_step == DIV_HIGH) && !link.divider_clear;
            next_state.cpu_clk = next_clk;
            rise_evt = clk_edge(next_clk, state.cpu_clk, 1'b1);
            fall_evt = clk_edge(next_clk, state.cpu_clk, 1'b0);
        end

        next_state.clk_rise = rise_evt;
        next_state.clk_fall = fall_evt;

        // first ready stage samples on the processor clock rise
        if (rise_evt)
        begin
            next_state.rdy_ff1 = rdy_valid;
        end

        if (fall_evt)
        begin
            case (link.sync_stage_sel)
                SYNC_ONE:
                begin
                    next_state.rdy_ff2 = rdy_valid;
                end
                SYNC_TWO:
                begin
                    // a rise needs stage one, a fall passes straight
                    if (rdy_valid)
                    begin
                        next_state.rdy_ff2 = state.rdy_ff1;
                    end
                    else
                    begin
                        next_state.rdy_ff2 = 1'b0;
                    end
                end
                default:
                begin
                    next_state.rdy_ff2 = 1'b0;
                end
            endcase
        end

        // peripheral clock toggles on processor clock falls only
        if (fall_evt)
        begin
            next_state.periph_clk = ~state.periph_clk;
        end

        // reset output resampled on each processor clock fall
        if (fall_evt)
        begin
            next_state.cpu_reset = ~link.reset_in_n;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state <= DEV_STATE_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ready stays until the next clock fall, past the hold time
    assign link.cpu_ready = state.rdy_ff2;
    assign link.cpu_clk = state.cpu_clk;
    assign link.periph_clk = state.periph_clk;
    assign link.cpu_reset = state.cpu_reset;
    assign link.osc_buffered_out = state.osc;

    assign cpu_clk_out = state.cpu_clk;
    assign periph_clk_out = state.periph_clk;
    assign ready_out = state.rdy_ff2;
    assign reset_out = state.cpu_reset;
    assign osc_out = state.osc;
    assign ext_src_out = state.src_ext;
    assign clk_rise_out = state.clk_rise;
    assign clk_fall_out = state.clk_fall;

endmodule : clock_gen_dev

// ==== logic/clock_gen_if.sv ====
interface clock_gen_if;
    logic xtal_in_a;
    logic ext_freq_in;
    logic ext_src_sel;
    logic divider_clear;
    logic bus_rdy_a;
    logic bus_rdy_b;
    logic bus_qual_a_n;
    logic bus_qual_b_n;
    logic sync_stage_sel;
    logic reset_in_n;
    logic cpu_clk;
    logic periph_clk;
    logic cpu_ready;
    logic cpu_reset;
    logic osc_buffered_out;

    modport dev (
        input xtal_in_a,
        input ext_freq_in,
        input ext_src_sel,
        input divider_clear,
        input bus_rdy_a,
        input bus_rdy_b,
        input bus_qual_a_n,
        input bus_qual_b_n,
        input sync_stage_sel,
        input reset_in_n,
        output cpu_clk,
        output periph_clk,
        output cpu_ready,
        output cpu_reset,
        output osc_buffered_out
    );

    modport sys (
        output xtal_in_a,
        output ext_freq_in,
        output ext_src_sel,
        output divider_clear,
        output bus_rdy_a,
        output bus_rdy_b,
        output bus_qual_a_n,
        output bus_qual_b_n,
        output sync_stage_sel,
        output reset_in_n,
        input cpu_clk,
        input periph_clk,
        input cpu_ready,
        input cpu_reset,
        input osc_buffered_out
    );
endinterface : clock_gen_if

// ==== logic/clock_gen_pkg.sv ====
package clock_gen_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // divide-by-three counter
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic [1:0] DIV_LAST = 2'h2;
    localparam logic [1:0] DIV_HIGH = 2'h2;

    // strap and mode encodings
    localparam logic SRC_XTAL = 1'b0;
    localparam logic SRC_EXT = 1'b1;
    localparam logic SYNC_TWO = 1'b0;
    localparam logic SYNC_ONE = 1'b1;

    // external frequency source, half period of the square wave
    localparam int EXT_HALF_NS = 20;
    localparam int EXT_HALF_CYC =
        (EXT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXT_CNT_W = 8;
    localparam logic [EXT_CNT_W-1:0] EXT_CNT_RESET = 8'h00;

    typedef struct packed {
        logic strap_taken;
        logic src_ext;
        logic src_prev;
        logic [1:0] div_cnt;
        logic cpu_clk;
        logic periph_clk;
        logic rdy_ff1;
        logic rdy_ff2;
        logic cpu_reset;
        logic osc;
        logic clk_rise;
        logic clk_fall;
    } dev_state_t;

    localparam dev_state_t DEV_STATE_RESET = '{
        strap_taken: 1'b0,
        src_ext: SRC_XTAL,
        src_prev: 1'b0,
        div_cnt: DIV_RESET,
        cpu_clk: 1'b0,
        periph_clk: 1'b0,
        rdy_ff1: 1'b0,
        rdy_ff2: 1'b0,
        cpu_reset: 1'b1,
        osc: 1'b0,
        clk_rise: 1'b0,
        clk_fall: 1'b0
    };

    typedef struct packed {
        logic [EXT_CNT_W-1:0] ext_cnt;
        logic ext_level;
        logic clr_s1;
        logic clr_s2;
        logic cpu_clk;
        logic periph_clk;
        logic ready;
        logic cpu_reset;
        logic osc;
    } sys_state_t;

    localparam sys_state_t SYS_STATE_RESET = '{
        ext_cnt: EXT_CNT_RESET,
        ext_level: 1'b0,
        clr_s1: 1'b0,
        clr_s2: 1'b0,
        cpu_clk: 1'b0,
        periph_clk: 1'b0,
        ready: 1'b0,
        cpu_reset: 1'b1,
        osc: 1'b0
    };

endpackage : clock_gen_pkg

// ==== logic/clock_gen_sys.sv ====
module clock_gen_sys
    import clock_gen_pkg::*;
#(
    parameter int EXT_HALF_CYCLES = EXT_HALF_CYC
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    clock_gen_if.sys link,
    input wire logic crystal_in,
    input wire logic use_ext_in,
    input wire logic clear_req_in,
    input wire logic multi_master_in,
    input wire logic qual_a_n_in,
    input wire logic qual_b_n_in,
    input wire logic xfer_done_a_in,
    input wire logic xfer_done_b_in,
    input wire logic sync_mode_in,
    input wire logic reset_req_n_in,
    output logic cpu_clk_out,
    output logic periph_clk_out,
    output logic ready_out,
    output logic reset_out,
    output logic osc_out
);

    localparam logic [EXT_CNT_W-1:0] EXT_LAST =
        EXT_CNT_W'(EXT_HALF_CYCLES - 1);

    sys_state_t state;
    sys_state_t next_state;
    logic ext_rise;

    assign ext_rise = (state.ext_cnt == EXT_LAST) && !state.ext_level;

    always_comb
    begin
        next_state = state;
        // square wave at three times the wanted processor clock
        if (state.ext_cnt == EXT_LAST)
        begin
            next_state.ext_cnt = EXT_CNT_RESET;
            next_state.ext_level = ~state.ext_level;
        end
        else
        begin
            next_state.ext_cnt = state.ext_cnt + 8'h01;
        end
        // clear passes two flops clocked by the source rise
        if (ext_rise)
        begin
            next_state.clr_s1 = clear_req_in;
            next_state.clr_s2 = state.clr_s1;
        end
        next_state.cpu_clk = link.cpu_clk;
        next_state.periph_clk = link.periph_clk;
        next_state.ready = link.cpu_ready;
        next_state.cpu_reset = link.cpu_reset;
        next_state.osc = link.osc_buffered_out;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state <= SYS_STATE_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign link.xtal_in_a = crystal_in;
    assign link.ext_src_sel = use_ext_in;
    assign link.ext_freq_in = use_ext_in & state.ext_level;
    assign link.divider_clear = use_ext_in & state.clr_s2;
    assign link.bus_rdy_a = xfer_done_a_in;
    assign link.bus_rdy_b = xfer_done_b_in;
    assign link.bus_qual_a_n = multi_master_in & qual_a_n_in;
    assign link.bus_qual_b_n = multi_master_in & qual_b_n_in;
    assign link.sync_stage_sel = sync_mode_in;
    assign link.reset_in_n = reset_req_n_in;

    assign cpu_clk_out = state.cpu_clk;
    assign periph_clk_out = state.periph_clk;
    assign ready_out = state.ready;
    assign reset_out = state.cpu_reset;
    assign osc_out = state.osc;

endmodule : clock_gen_sys

// ==== testbench/clock_gen_chk.sv ====
module clock_gen_chk
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic xtal_in_a,
    input wire logic divider_clear,
    input wire logic bus_rdy_a,
    input wire logic bus_rdy_b,
    input wire logic bus_qual_a_n,
    input wire logic bus_qual_b_n,
    input wire logic sync_stage_sel,
    input wire logic reset_in_n,
    input wire logic cpu_clk,
    input wire logic periph_clk,
    input wire logic cpu_ready,
    input wire logic cpu_reset,
    input wire logic osc_buffered_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    logic rv;
    logic s1;
    logic rv_q;
    logic clk_q;
    assign rv = (bus_rdy_a & ~bus_qual_a_n) | (bus_rdy_b & ~bus_qual_b_n);
    // stage one sample taken at each clock rise
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s1 <= 1'b0;
            rv_q <= 1'b0;
            clk_q <= 1'b0;
        end
        else
        begin
            rv_q <= rv;
            clk_q <= cpu_clk;
            if (cpu_clk && !clk_q)
                s1 <= rv_q;
        end
    end
    chk_osc_copy:
    assert property ($past(rst_b_in) |->
        osc_buffered_out == $past(xtal_in_a))
        else $error("osc not a copy of crystal");
    chk_clk_third:
    assert property (disable iff (!rst_b_in || divider_clear)
        $rose(cpu_clk) |-> cpu_clk[*2] ##1 !cpu_clk[*4] ##1 cpu_clk)
        else $error("clock not a third");
    chk_periph_edge:
    assert property ($changed(periph_clk) == $fell(cpu_clk))
        else $error("peripheral clock off phase");
    chk_reset_edge:
    assert property ($changed(cpu_reset) |-> $fell(cpu_clk))
        else $error("reset moved off clock fall");
    chk_reset_value:
    assert property ($fell(cpu_clk) |-> cpu_reset == !$past(reset_in_n))
        else $error("reset value wrong");
    chk_clear_hold:
    assert property (divider_clear && !cpu_clk |=> !cpu_clk)
        else $error("clock ran during clear");
    chk_ready_one:
    assert property ($fell(cpu_clk) && $past(sync_stage_sel) |->
        cpu_ready == $past(rv))
        else $error("one stage ready wrong");
    chk_ready_two:
    assert property ($fell(cpu_clk) && !$past(sync_stage_sel) |->
        cpu_ready == (s1 && $past(rv)))
        else $error("two stage ready wrong");
    chk_ready_hold:
    assert property (!$fell(cpu_clk) |-> $stable(cpu_ready))
        else $error("ready moved off clock fall");
    cover property ($rose(cpu_ready) && !sync_stage_sel);
    cover property ($fell(divider_clear));
    cover property ($fell(cpu_reset));
endmodule : clock_gen_chk

// ==== testbench/tb.sv ====
module tb
    import clock_gen_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic xtal = 1'b0;
    logic use_ext = SRC_EXT;
    logic clr = 1'b0;
    logic mm = 1'b1;
    logic qa_n = 1'b1;
    logic qb_n = 1'b1;
    logic da = 1'b0;
    logic db = 1'b0;
    logic smode = SYNC_TWO;
    logic res_n = 1'b1;
    logic cpu_clk, pclk, ready, rst_out, osc, ext_src;
    logic [3:0] obs;
    logic rise, fall;
    logic [4:0] dev_obs;
    logic [4:0] sys_obs;
    int fail_count = 0;
    int cmp_count = 0;
    clock_gen_if link ();
    assign obs = {pclk, rst_out, ready, cpu_clk};
    assign dev_obs = {osc, pclk, rst_out, ready, cpu_clk};
    always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;
    always @(negedge clk_in) xtal <= ~xtal;
    clock_gen_dev i_clock_gen_dev (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .link(link.dev), .cpu_clk_out(cpu_clk), .periph_clk_out(pclk),
        .ready_out(ready), .reset_out(rst_out), .osc_out(osc),
        .ext_src_out(ext_src), .clk_rise_out(rise), .clk_fall_out(fall));
    // fastest external square wave, three source periods per clock
    clock_gen_sys #(.EXT_HALF_CYCLES(1)) i_clock_gen_sys (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .link(link.sys),
        .crystal_in(xtal), .use_ext_in(use_ext), .clear_req_in(clr),
        .multi_master_in(mm), .qual_a_n_in(qa_n), .qual_b_n_in(qb_n),
        .xfer_done_a_in(da), .xfer_done_b_in(db), .sync_mode_in(smode),
        .reset_req_n_in(res_n), .cpu_clk_out(sys_obs[0]),
        .periph_clk_out(sys_obs[3]), .ready_out(sys_obs[1]),
        .reset_out(sys_obs[2]), .osc_out(sys_obs[4]));
    clock_gen_chk i_clock_gen_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .xtal_in_a(link.xtal_in_a), .divider_clear(link.divider_clear),
        .bus_rdy_a(link.bus_rdy_a), .bus_rdy_b(link.bus_rdy_b),
        .bus_qual_a_n(link.bus_qual_a_n), .bus_qual_b_n(link.bus_qual_b_n),
        .sync_stage_sel(link.sync_stage_sel), .reset_in_n(link.reset_in_n),
        .cpu_clk(link.cpu_clk), .periph_clk(link.periph_clk),
        .cpu_ready(link.cpu_ready), .cpu_reset(link.cpu_reset),
        .osc_buffered_out(link.osc_buffered_out));
    task summarize;
        $display("mismatches %0d, compares %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task wait_for(input int w, input logic v);
        int k;
        k = 0;
        while (obs[w] !== v && k < 60)
        begin
            @(negedge clk_in);
            k++;
        end
        check(8'(obs[w]), 8'(v));
        if (obs[w] !== v)
            summarize();
    endtask : wait_for
    task do_reset(input logic src);
        @(negedge clk_in);
        rst_b_in = 1'b0;
        use_ext = src;
        repeat (2) @(negedge clk_in);
        rst_b_in = 1'b1;
        repeat (4) @(negedge clk_in);
    endtask : do_reset
    task t_clock(input logic src);
        int hi, pc, rc, fc;
        logic [4:0] last;
        hi = 0;
        pc = 0;
        rc = 0;
        fc = 0;
        last = dev_obs;
        check(8'(ext_src), 8'(src));
        repeat (12)
        begin
            @(posedge clk_in);
            #1;
            hi += cpu_clk;
            pc += pclk;
            rc += rise;
            fc += fall;
            check(8'(osc), 8'(xtal));
            check(8'(sys_obs), 8'(last));
            last = dev_obs;
        end
        check(8'(hi), 8'h04);
        check(8'(pc), 8'h06);
        check(8'(rc), 8'h02);
        check(8'(fc), 8'h02);
        @(negedge clk_in);
    endtask : t_clock
    task t_ready;
        qa_n = 1'b0;
        da = 1'b1;
        wait_for(1, 1'b1);
        check(8'(cpu_clk), 8'h00);
        qa_n = 1'b1;
        wait_for(1, 1'b0);
        repeat (20) @(negedge clk_in);
        check(8'(ready), 8'h00);
        smode = SYNC_ONE;
        qb_n = 1'b0;
        db = 1'b1;
        wait_for(1, 1'b1);
        db = 1'b0;
        wait_for(1, 1'b0);
        mm = 1'b0;
        qb_n = 1'b1;
        wait_for(1, 1'b1);
        da = 1'b0;
        wait_for(1, 1'b0);
    endtask : t_ready
    task t_reset;
        res_n = 1'b0;
        wait_for(2, 1'b1);
        res_n = 1'b1;
        wait_for(2, 1'b0);
    endtask : t_reset
    task t_clear;
        int hi;
        hi = 0;
        clr = 1'b1;
        repeat (8) @(negedge clk_in);
        repeat (20)
        begin
            @(negedge clk_in);
            hi += cpu_clk;
        end
        check(8'(hi), 8'h00);
        clr = 1'b0;
        wait_for(0, 1'b1);
    endtask : t_clear
    initial
    begin
        do_reset(SRC_EXT);
        wait_for(2, 1'b0);
        t_clock(SRC_EXT);
        t_ready();
        t_reset();
        t_clear();
        // crystal source keeps the clear low
        do_reset(SRC_XTAL);
        wait_for(2, 1'b0);
        t_clock(SRC_XTAL);
        summarize();
    end
endmodule : tb
